// *** slc_pkg.sv ***
// Package with field layout, defaults, types and the list of loop configuration behaviours
// Contract
// - Double-buffer bit set holds output-divider writes in shadow; clear applies them; default clear.
// - Four-bit pump current code maps to sixteen ascending steps, 0.31 to 5.00 mA.
// - Lock declared after 40 good detector cycles (bit 0) or 5 (bit 1).
// - Lock precision bit picks phase window: 0 gives 10ns, 1 gives 6ns.
// - Detector sense bit: 0 negative, 1 positive; default positive.
// - Sleep bit 1 enters power-down, 0 normal; resets to 0.
// - Pump tristate bit 1 floats pump output, 0 drives; default 0.
// - Code 010 in low three bits loads the loop control register only.
// - Code 011 in low three bits loads the clock divider register only.
// - Band sequence rate bit: 0 slow about 125kHz, 1 fast up to 500kHz.
// - Divider role: 00 off, 01 fast lock, 10 resync, 11 reserved.
// - Divider ratio equals 12-bit value 1 to 4095, default 1, never zero.
// - Output divide code selects divide 1 to 64; all-ones code reserved.
package slc_pkg;

   localparam int WORD_BITS = 32;

   // Register select codes in the low three bits
   localparam logic [2:0] SEL_LATCH_OUT  = 3'h0;
   localparam logic [2:0] SEL_LOOP_CTRL  = 3'h2;
   localparam logic [2:0] SEL_CLK_DIV    = 3'h3;
   localparam logic [2:0] SEL_OUTPUT_REG = 3'h4;

   // Loop control register field positions
   localparam int POS_SHADOW_EN   = 13;
   localparam int POS_PUMP_CODE   = 9;
   localparam int POS_LOCK_COUNT  = 8;
   localparam int POS_LOCK_WINDOW = 7;
   localparam int POS_SENSE       = 6;
   localparam int POS_SLEEP       = 5;
   localparam int POS_TRISTATE    = 4;

   // Clock divider register field positions
   localparam int POS_BAND_RATE   = 23;
   localparam int POS_DIV_ROLE    = 15;
   localparam int POS_DIV_RATIO   = 3;

   // Output register field positions
   localparam int POS_OUT_DIV     = 20;
   localparam int POS_BAND_DIV    = 12;

   // Reset values and the reserved output divide code
   localparam logic [3:0]  RST_PUMP_CODE = 4'h0;
   localparam logic [1:0]  RST_DIV_ROLE  = 2'h0;
   localparam logic [11:0] RST_DIV_RATIO = 12'h001;
   localparam logic [2:0]  RST_OUT_DIV   = 3'h0;
   localparam logic [7:0]  RST_BAND_DIV  = 8'h01;
   localparam logic [2:0]  OUT_DIV_RSVD  = 3'h7;

   // Lock detector figures
   localparam int LOCK_CYCLES_FRAC = 40;
   localparam int LOCK_CYCLES_INT  = 5;
   localparam int WINDOW_WIDE_NS   = 10;
   localparam int WINDOW_NARROW_NS = 6;

   typedef enum logic [1:0] {
      ROLE_OFF,
      ROLE_FAST_LOCK,
      ROLE_RESYNC,
      ROLE_RESERVED
   } slc_role_t;

   typedef struct packed {
      logic       shadow_update_en;
      logic [3:0] pump_current_code;
      logic       lock_cycle_count_sel;
      logic       lock_window_sel;
      logic       detector_sense_sel;
      logic       sleep_bit;
      logic       pump_tristate;
   } slc_loop_t;

   typedef struct packed {
      logic       band_seq_rate_sel;
      slc_role_t  divider_role_sel;
      logic [11:0] divider_ratio;
   } slc_clkdiv_t;

   // Pump current in units of 10 uA, one step per code
   function automatic logic [9:0] pump_current_10ua(input logic [3:0] code);
      logic [9:0] cur;
      cur = 10'h000;
      case (code)
         4'h0: cur = 10'd31;
         4'h1: cur = 10'd63;
         4'h2: cur = 10'd94;
         4'h3: cur = 10'd125;
         4'h4: cur = 10'd156;
         4'h5: cur = 10'd188;
         4'h6: cur = 10'd219;
         4'h7: cur = 10'd250;
         4'h8: cur = 10'd281;
         4'h9: cur = 10'd313;
         4'hA: cur = 10'd344;
         4'hB: cur = 10'd375;
         4'hC: cur = 10'd406;
         4'hD: cur = 10'd438;
         4'hE: cur = 10'd469;
         default: cur = 10'd500;
      endcase
      return cur;
   endfunction

endpackage

// *** slc_lock_detect.sv ***
// Lock detector counting consecutive in-window phase detector cycles
`timescale 1ns/1ps
`default_nettype none
module slc_lock_detect
   import slc_pkg::*;
#(
   parameter int CYCLES_FRAC = LOCK_CYCLES_FRAC,
   parameter int CYCLES_INT  = LOCK_CYCLES_INT
) (
   input  wire logic       clock,
   input  wire logic       resetn,
   input  wire logic       pfd_strobe,
   input  wire logic [7:0] phase_err_ns,
   input  wire logic       count_sel,
   input  wire logic       window_sel,
   input  wire logic       sleep,
   output var  logic       locked
);

   logic [5:0] good_count;
   logic [5:0] target;
   logic [7:0] window;
   logic       in_window;

   assign target    = count_sel ? 6'(CYCLES_INT) : 6'(CYCLES_FRAC);
   assign window    = window_sel ? 8'(WINDOW_NARROW_NS) : 8'(WINDOW_WIDE_NS);
   assign in_window = phase_err_ns < window;

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         good_count <= 6'h00;
      end else if (sleep) begin
         good_count <= 6'h00;
      end else if (pfd_strobe) begin
         if (!in_window) begin
            good_count <= 6'h00;
         end else if (good_count < target) begin
            good_count <= good_count + 6'h01;
         end
      end
   end

   // One bad cycle drops lock at once; counting must restart from zero
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         locked <= 1'b0;
      end else if (sleep || (pfd_strobe && !in_window)) begin
         locked <= 1'b0;
      end else if (pfd_strobe && good_count + 6'h01 >= target) begin
         locked <= 1'b1;
      end
   end

endmodule
`default_nettype wire

// *** slc_regs.sv ***
// Serial-loaded loop and clock divider configuration registers of the synthesizer
`timescale 1ns/1ps
`default_nettype none
module slc_regs
   import slc_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        resetn,
   input  wire logic        ser_clk,
   input  wire logic        ser_data,
   input  wire logic        ser_load,
   input  wire logic        pfd_strobe,
   input  wire logic [7:0]  phase_err_ns,
   output var  slc_loop_t   loop_cfg,
   output var  slc_clkdiv_t clkdiv_cfg,
   output var  logic [9:0]  pump_current_10ua_out,
   output var  logic        pump_out_en,
   output var  logic        sense_positive,
   output var  logic        power_down,
   output var  logic        fast_lock_en,
   output var  logic        resync_en,
   output var  logic [2:0]  output_divide_code,
   output var  logic [6:0]  output_divide_ratio,
   output var  logic [7:0]  band_seq_clk_div,
   output var  logic        lock_detect
);

   logic [WORD_BITS-1:0] shift;
   logic [WORD_BITS-1:0] word;
   logic                 ser_clk_q;
   logic                 ser_load_q;
   logic                 bit_in;
   logic                 word_done;
   logic [2:0]           sel;
   logic [2:0]           shadow_div;
   logic [2:0]           new_div;
   logic [11:0]          new_ratio;

   // Inputs are synchronous to clock, so a plain previous-value edge detect is safe
   assign bit_in    = ser_clk & ~ser_clk_q;
   assign word_done = ser_load & ~ser_load_q;
   assign word      = shift;
   assign sel       = word[2:0];
   assign new_div   = word[POS_OUT_DIV +: 3];
   assign new_ratio = word[POS_DIV_RATIO +: 12];

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         ser_clk_q  <= 1'b0;
         ser_load_q <= 1'b0;
      end else begin
         ser_clk_q  <= ser_clk;
         ser_load_q <= ser_load;
      end
   end

   // Word shifts in MSB first
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         shift <= 32'h0000_0000;
      end else if (bit_in) begin
         shift <= {shift[WORD_BITS-2:0], ser_data};
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         loop_cfg.shadow_update_en     <= 1'b0;
         loop_cfg.pump_current_code    <= RST_PUMP_CODE;
         loop_cfg.lock_cycle_count_sel <= 1'b0;
         loop_cfg.lock_window_sel      <= 1'b0;
         loop_cfg.detector_sense_sel   <= 1'b1;
         loop_cfg.sleep_bit            <= 1'b0;
         loop_cfg.pump_tristate        <= 1'b0;
      end else if (word_done && sel == SEL_LOOP_CTRL) begin
         loop_cfg.shadow_update_en     <= word[POS_SHADOW_EN];
         loop_cfg.pump_current_code    <= word[POS_PUMP_CODE +: 4];
         loop_cfg.lock_cycle_count_sel <= word[POS_LOCK_COUNT];
         loop_cfg.lock_window_sel      <= word[POS_LOCK_WINDOW];
         loop_cfg.detector_sense_sel   <= word[POS_SENSE];
         loop_cfg.sleep_bit            <= word[POS_SLEEP];
         loop_cfg.pump_tristate        <= word[POS_TRISTATE];
      end
   end

   // A zero ratio is not allowed, so such a write keeps the old ratio
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         clkdiv_cfg.band_seq_rate_sel <= 1'b0;
         clkdiv_cfg.divider_role_sel  <= ROLE_OFF;
         clkdiv_cfg.divider_ratio     <= RST_DIV_RATIO;
      end else if (word_done && sel == SEL_CLK_DIV) begin
         clkdiv_cfg.band_seq_rate_sel <= word[POS_BAND_RATE];
         clkdiv_cfg.divider_role_sel  <= slc_role_t'(word[POS_DIV_ROLE +: 2]);
         if (new_ratio != 12'h000) begin
            clkdiv_cfg.divider_ratio <= new_ratio;
         end
      end
   end

   // Output divider: staged while double buffering, released by the next latch-out word
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         shadow_div         <= RST_OUT_DIV;
         output_divide_code <= RST_OUT_DIV;
         band_seq_clk_div   <= RST_BAND_DIV;
      end else if (word_done && sel == SEL_OUTPUT_REG) begin
         if (word[POS_BAND_DIV +: 8] != 8'h00) begin
            band_seq_clk_div <= word[POS_BAND_DIV +: 8];
         end
         if (new_div != OUT_DIV_RSVD) begin
            shadow_div <= new_div;
            if (!loop_cfg.shadow_update_en) begin
               output_divide_code <= new_div;
            end
         end
      end else if (word_done && sel == SEL_LATCH_OUT && loop_cfg.shadow_update_en) begin
         output_divide_code <= shadow_div;
      end
   end

   // Decoded outputs lag their field by one clock so every port is a flop
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         pump_current_10ua_out <= 10'd31;
         pump_out_en           <= 1'b1;
         sense_positive        <= 1'b1;
         power_down            <= 1'b0;
         fast_lock_en          <= 1'b0;
         resync_en             <= 1'b0;
         output_divide_ratio   <= 7'h01;
      end else begin
         pump_current_10ua_out <= pump_current_10ua(loop_cfg.pump_current_code);
         pump_out_en           <= ~loop_cfg.pump_tristate & ~loop_cfg.sleep_bit;
         sense_positive        <= loop_cfg.detector_sense_sel;
         power_down            <= loop_cfg.sleep_bit;
         fast_lock_en          <= clkdiv_cfg.divider_role_sel == ROLE_FAST_LOCK;
         resync_en             <= clkdiv_cfg.divider_role_sel == ROLE_RESYNC;
         output_divide_ratio   <= 7'h01 << output_divide_code;
      end
   end

   slc_lock_detect #(
      .CYCLES_FRAC (LOCK_CYCLES_FRAC),
      .CYCLES_INT  (LOCK_CYCLES_INT)
   ) u_lock (
      .clock        (clock),
      .resetn       (resetn),
      .pfd_strobe   (pfd_strobe),
      .phase_err_ns (phase_err_ns),
      .count_sel    (loop_cfg.lock_cycle_count_sel),
      .window_sel   (loop_cfg.lock_window_sel),
      .sleep        (loop_cfg.sleep_bit),
      .locked       (lock_detect)
   );

endmodule
`default_nettype wire

// *** slc_regs_checker.sv ***
// Concurrent checks on the configuration register ports
`timescale 1ns/1ps
`default_nettype none
module slc_regs_checker
   import slc_pkg::*;
(
   input wire logic        clock,
   input wire logic        resetn,
   input wire logic        ser_clk,
   input wire logic        ser_data,
   input wire logic        ser_load,
   input wire logic        pfd_strobe,
   input wire logic [7:0]  phase_err_ns,
   input wire slc_loop_t   loop_cfg,
   input wire slc_clkdiv_t clkdiv_cfg,
   input wire logic [9:0]  pump_current_10ua_out,
   input wire logic        pump_out_en,
   input wire logic        sense_positive,
   input wire logic        power_down,
   input wire logic        fast_lock_en,
   input wire logic        resync_en,
   input wire logic [2:0]  output_divide_code,
   input wire logic [6:0]  output_divide_ratio,
   input wire logic [7:0]  band_seq_clk_div,
   input wire logic        lock_detect
);
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   // A strobe outside the window of the selected precision
   sequence bad_strobe;
      lock_detect && pfd_strobe && phase_err_ns >= (loop_cfg.lock_window_sel ? 8'h06 : 8'h0a);
   endsequence
   a_cfg_needs_load: assert property (!ser_load |=> $stable(loop_cfg) && $stable(clkdiv_cfg))
      else $error("configuration changed without a latched word");
   a_pump_top_code: assert property (loop_cfg.pump_current_code == 4'hf |=> pump_current_10ua_out == 10'h1f4)
      else $error("top pump code not decoded to full current");
   a_pump_drive_en: assert property (pump_out_en != ($past(loop_cfg.pump_tristate) || $past(loop_cfg.sleep_bit)))
      else $error("pump drive enable wrong");
   a_sleep_sense: assert property ({power_down, sense_positive} == $past({loop_cfg.sleep_bit, loop_cfg.detector_sense_sel}))
      else $error("power down or sense output wrong");
   a_role_decode: assert property ({fast_lock_en, resync_en} == {$past(clkdiv_cfg.divider_role_sel) == ROLE_FAST_LOCK,
                                    $past(clkdiv_cfg.divider_role_sel) == ROLE_RESYNC})
      else $error("divider role decode wrong");
   a_out_ratio: assert property (output_divide_ratio == 7'h01 << $past(output_divide_code))
      else $error("output divide ratio wrong");
   a_ratio_nonzero: assert property (clkdiv_cfg.divider_ratio != 12'h000)
      else $error("zero divider ratio held");
   a_code_legal: assert property (output_divide_code != OUT_DIV_RSVD)
      else $error("reserved output divide code applied");
   a_lock_drop: assert property (bad_strobe |-> ##[1:2] !lock_detect)
      else $error("lock kept after bad strobe");
   a_sleep_unlock: assert property (loop_cfg.sleep_bit |-> ##[1:2] !lock_detect)
      else $error("lock shown in power down");
endmodule
bind slc_regs slc_regs_checker u_chk (.clock(clock), .resetn(resetn), .ser_clk(ser_clk), .ser_data(ser_data),
   .ser_load(ser_load), .pfd_strobe(pfd_strobe), .phase_err_ns(phase_err_ns), .loop_cfg(loop_cfg),
   .clkdiv_cfg(clkdiv_cfg), .pump_current_10ua_out(pump_current_10ua_out), .pump_out_en(pump_out_en),
   .sense_positive(sense_positive), .power_down(power_down), .fast_lock_en(fast_lock_en), .resync_en(resync_en),
   .output_divide_code(output_divide_code), .output_divide_ratio(output_divide_ratio),
   .band_seq_clk_div(band_seq_clk_div), .lock_detect(lock_detect));
`default_nettype wire

// *** slc_host_model.sv ***
// Host model shifting configuration words into the serial port
`timescale 1ns/1ps
`default_nettype none
module slc_host_model (
   input  wire logic clock,
   output var  logic ser_clk,
   output var  logic ser_data,
   output var  logic ser_load
);
   initial begin
      ser_clk = 1'b0;
      ser_data = 1'b0;
      ser_load = 1'b0;
   end
   // Select code rides in the low three bits of every word
   task automatic send(input logic [31:0] w);
      for (int i = 31; i >= 0; i--) begin
         @(posedge clock) #1 ser_clk = 1'b0;
         ser_data = w[i];
         @(posedge clock) #1 ser_clk = 1'b1;
      end
      @(posedge clock) #1 ser_clk = 1'b0;
      // Released data line must not look like a held bit
      ser_data = ~w[0];
      ser_load = 1'b1;
      @(posedge clock) #1 ser_load = 1'b0;
      repeat (3) @(posedge clock);
      #1;
   endtask
endmodule
`default_nettype wire

// *** slc_regs_tb.sv ***
// Self-checking bench for the loop and clock divider configuration registers
`timescale 1ns/1ps
`default_nettype none
module slc_regs_tb;
   import slc_pkg::*;
   logic        clock, resetn, pfd_strobe, ser_clk, ser_data, ser_load;
   logic [7:0]  phase_err_ns, band_seq_clk_div;
   slc_loop_t   loop_cfg;
   slc_clkdiv_t clkdiv_cfg;
   logic [9:0]  pump_current_10ua_out;
   logic        pump_out_en, sense_positive, power_down, fast_lock_en, resync_en, lock_detect;
   logic [2:0]  output_divide_code;
   logic [6:0]  output_divide_ratio;
   int          miscompares = 0;
   int          total_checks = 0;
   logic [9:0]  cur_tab [16] = '{10'h01f, 10'h03f, 10'h05e, 10'h07d, 10'h09c, 10'h0bc, 10'h0db, 10'h0fa,
                                 10'h119, 10'h139, 10'h158, 10'h177, 10'h196, 10'h1b6, 10'h1d5, 10'h1f4};
   slc_host_model host (.clock(clock), .ser_clk(ser_clk), .ser_data(ser_data), .ser_load(ser_load));
   slc_regs DUT (.clock(clock), .resetn(resetn), .ser_clk(ser_clk), .ser_data(ser_data), .ser_load(ser_load),
      .pfd_strobe(pfd_strobe), .phase_err_ns(phase_err_ns), .loop_cfg(loop_cfg), .clkdiv_cfg(clkdiv_cfg),
      .pump_current_10ua_out(pump_current_10ua_out), .pump_out_en(pump_out_en), .sense_positive(sense_positive),
      .power_down(power_down), .fast_lock_en(fast_lock_en), .resync_en(resync_en),
      .output_divide_code(output_divide_code), .output_divide_ratio(output_divide_ratio),
      .band_seq_clk_div(band_seq_clk_div), .lock_detect(lock_detect));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic final_report;
      if (miscompares == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Flags f: shadow, count, window, sense, sleep, tristate
   function automatic logic [31:0] loopw(input logic [3:0] pc, input logic [5:0] f);
      return 32'(f[5]) << POS_SHADOW_EN | 32'(pc) << POS_PUMP_CODE | 32'(f[4:0]) << POS_TRISTATE | 32'(SEL_LOOP_CTRL);
   endfunction
   function automatic logic [31:0] outw(input logic [2:0] d, input logic [7:0] b);
      return 32'(d) << POS_OUT_DIV | 32'(b) << POS_BAND_DIV | 32'(SEL_OUTPUT_REG);
   endfunction
   task automatic strobes(input int n, input logic [7:0] e);
      repeat (n) begin
         @(posedge clock) #1 pfd_strobe = 1'b1;
         phase_err_ns = e;
      end
      @(posedge clock) #1 pfd_strobe = 1'b0;
      repeat (3) @(posedge clock);
      #1;
   endtask
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   initial begin
      #400_000;
      miscompares++;
      final_report;
   end
   initial begin
      resetn = 1'b0;
      pfd_strobe = 1'b0;
      phase_err_ns = 8'h00;
      repeat (5) @(posedge clock);
      #1 resetn = 1'b1;
      chk(loop_cfg, 10'h004);
      chk(clkdiv_cfg, 15'h0001);
      chk({pump_current_10ua_out, pump_out_en, power_down, output_divide_ratio, band_seq_clk_div},
          {10'h01f, 2'h2, 7'h01, 8'h01});
      for (int c = 0; c < 16; c++) begin
         host.send(loopw(4'(c), 6'h04));
         chk(pump_current_10ua_out, cur_tab[c]);
      end
      host.send(loopw(4'h0, 6'h1b));
      chk({loop_cfg, pump_out_en, power_down, sense_positive}, {10'h01b, 3'h2});
      strobes(6, 8'h01);
      chk(lock_detect, 1'b0);
      host.send(loopw(4'h0, 6'h19));
      chk({pump_out_en, power_down, sense_positive}, 3'h0);
      strobes(4, 8'h05);
      chk(lock_detect, 1'b0);
      strobes(1, 8'h05);
      chk(lock_detect, 1'b1);
      strobes(1, 8'h06);
      chk(lock_detect, 1'b0);
      host.send(loopw(4'h0, 6'h00));
      strobes(39, 8'h09);
      chk(lock_detect, 1'b0);
      strobes(1, 8'h09);
      chk(lock_detect, 1'b1);
      foreach (cur_tab[s]) begin
         if (s != 2 && s < 8) begin
            host.send(loopw(4'hf, 6'h3f) & ~32'h0000_0007 | 32'(s));
            chk(loop_cfg, 10'h000);
         end
      end
      for (int r = 0; r < 4; r++) begin
         host.send(32'h0080_0000 | 32'(r) << POS_DIV_ROLE | 32'h0000_7ff8 | 32'(SEL_CLK_DIV));
         chk({clkdiv_cfg, fast_lock_en, resync_en}, {1'b1, 2'(r), 12'hfff, r == 1, r == 2});
      end
      chk(loop_cfg, 10'h000);
      host.send(32'(SEL_CLK_DIV));
      chk(clkdiv_cfg, 15'h0fff);
      host.send(outw(3'h3, 8'hfe));
      chk({output_divide_code, output_divide_ratio, band_seq_clk_div}, {3'h3, 7'h08, 8'hfe});
      host.send(outw(3'h7, 8'h00));
      chk({output_divide_code, output_divide_ratio, band_seq_clk_div}, {3'h3, 7'h08, 8'hfe});
      host.send(loopw(4'h0, 6'h20));
      host.send(outw(3'h6, 8'hfe));
      chk(output_divide_code, 3'h3);
      host.send(32'h0000_0000);
      chk({output_divide_code, output_divide_ratio}, {3'h6, 7'h40});
      final_report;
   end
endmodule
`default_nettype wire
